//--- design/ets_trigger_sel.sv
// external trigger selector top: ahb-lite registers, pedal switch
// decoding, midi source matching, capture and activity strobe.
// assumes pedal contacts are debounced and synchronous, 1 = shorted
// to sleeve; mod values and midi bytes are synchronous to clk_i.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ets_trigger_sel (
	input  wire logic               clk_i,        // 100 MHz clock
	input  wire logic               sys_rst_i,    // sync reset, high
	input  wire logic               hsel_i,       // ahb select
	input  wire logic [31:0]        haddr_i,      // ahb address
	input  wire logic [1:0]         htrans_i,     // ahb transfer type
	input  wire logic               hwrite_i,     // ahb write
	input  wire logic [2:0]         hsize_i,      // ahb size
	input  wire logic [31:0]        hwdata_i,     // ahb write data
	input  wire logic               hready_i,     // ahb bus ready
	output logic [31:0]             hrdata_o,     // ahb read data
	output logic                    hreadyout_o,  // ahb slave ready
	output logic                    hresp_o,      // ahb response
	input  wire logic [7:0]         midi_byte_i,  // midi byte
	input  wire logic               midi_vld_i,   // midi byte strobe
	input  wire logic [1:0]         tip_i,        // tip shorted, per socket
	input  wire logic [1:0]         ring_i,       // ring shorted, per socket
	input  wire logic [1:0]         tr_ref_i,     // other user of tip&ring
	input  wire logic [3:0][7:0]    mod_val_i,    // modulation values
	input  wire logic               card_i,       // memory card present
	output logic                    trig_o,       // trigger pulse
	output logic                    busy_o        // activity pulse
);
	import ets_pkg::*;

	// configuration
	ets_src_type sel_r;
	logic [3:0]  cho_r;
	logic [6:0]  con_r;
	logic [3:0]  base_r;
	logic        omni_r;
	logic        men_r;
	logic        cap_r;

	// bus
	logic        ap;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [7:0]  addr_r;
	logic        hready_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;

	// trigger path
	ets_msg_type msg;
	logic [5:0]  ped;
	logic [1:0]  three;
	logic [4:0]  ch_sum;
	logic [3:0]  ch_eff;
	logic        ch_ok;
	logic        cc_hit;
	logic [6:0]  cc_num;
	logic        cc_sel;
	logic        ev_hit;
	logic        lvl_r;
	logic        lvl_nxt;
	logic [6:0]  dbl_hi_r;
	logic [6:0]  dbl_lo_r;
	logic        trig_r;
	logic        busy_r;

	// capture
	logic        cap_ok;
	ets_src_type cap_src;
	logic [3:0]  cap_cho;
	logic        cap_wr;

	assign hrdata_o    = hrdata_r;
	assign hreadyout_o = hready_r;
	assign hresp_o     = 1'b0;
	assign trig_o      = trig_r;
	assign busy_o      = busy_r;

	ets_midi_parser u_parser (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.byte_i     (midi_byte_i),
		.byte_vld_i (midi_vld_i),
		.midi_en_i  (men_r),
		.msg_o      (msg)
	);

	// ---- ahb-lite slave ----
	// writes complete with no wait; reads take one wait so a read right
	// after a write sees the written value
	assign ap = hsel_i & htrans_i[1] & hready_i;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
			hready_r  <= 1'b1;
		end else begin
			wr_pend_r <= ap & hwrite_i;
			rd_pend_r <= ap & ~hwrite_i;
			hready_r  <= ~(ap & ~hwrite_i);
			if (ap) begin
				addr_r <= haddr_i[7:0];
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_r == ETS_OFS_SRC) begin
			rd_mux[ETS_SEL_LSB +: ETS_SEL_W] = sel_r;
			rd_mux[ETS_CHO_LSB +: 4]         = cho_r;
			rd_mux[ETS_CON_LSB +: 7]         = con_r;
		end else if (addr_r == ETS_OFS_CFG) begin
			rd_mux[ETS_BASE_LSB +: 4] = base_r;
			rd_mux[ETS_OMNI_BIT]      = omni_r;
			rd_mux[ETS_MEN_BIT]       = men_r;
		end else if (addr_r == ETS_OFS_CAP) begin
			rd_mux[ETS_CAP_BIT] = cap_r;
		end else if (addr_r == ETS_OFS_STAT) begin
			rd_mux[ETS_ST_CAP_BIT]            = cap_r;
			rd_mux[ETS_ST_LVL_BIT]            = lvl_r;
			rd_mux[ETS_ST_PED_LSB +: 6]       = ped;
			rd_mux[ETS_ST_SEL_LSB +: 2]       = three;
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_mux;
		end
	end

	// ---- channel filter ----
	// base is held zero-based, so channel 16 + 1 wraps to index 0
	assign ch_sum = {1'b0, base_r} + {1'b0, cho_r};
	assign ch_eff = (ch_sum > CH_MAX) ? 4'(ch_sum - CH_COUNT) : ch_sum[3:0];
	assign ch_ok  = omni_r | (msg.chan == ch_eff);

	// ---- capture mapping ----
	always_comb begin
		cap_ok  = 1'b1;
		cap_src = SRC_OFF;
		case (msg.kind)
			K_NOFF, K_NON: cap_src = SRC_NOTE;
			K_PROG:        cap_src = SRC_PROG;
			K_START:       cap_src = SRC_START;
			K_STOP:        cap_src = SRC_STOP;
			K_CC: begin
				if (msg.d1 == CC_DAMP) begin
					cap_src = SRC_DAMP;
				end else if (msg.d1 == CC_PORTA) begin
					cap_src = SRC_PORTA;
				end else if (msg.d1 == CC_SOST) begin
					cap_src = SRC_SOST;
				end else if (msg.d1 == CC_SOFT) begin
					cap_src = SRC_SOFT;
				end else if (msg.d1 == CC_HOLD2) begin
					cap_src = SRC_HOLD2;
				end else if (msg.d1[6:2] == CC_GEN5[6:2]) begin
					cap_src = ets_src_type'(SRC_GEN5 + {3'b000, msg.d1[1:0]});
				end else begin
					cap_src = SRC_SINGLE;
				end
			end
			// no trigger form for these: capture keeps waiting
			default: cap_ok = 1'b0;
		endcase
	end

	// channel stored relative to base; start/stop carry none
	assign cap_cho = msg.chan - base_r;
	assign cap_wr  = wr_pend_r & (addr_r == ETS_OFS_CAP) & hwdata_i[ETS_CAP_BIT];

	// ---- configuration registers and capture ----
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sel_r  <= SRC_OFF;
			cho_r  <= 4'h0;
			con_r  <= 7'h00;
			base_r <= ETS_BASE_RST;
			omni_r <= ETS_OMNI_RST;
			men_r  <= ETS_MEN_RST;
			cap_r  <= 1'b0;
		end else begin
			if (wr_pend_r && addr_r == ETS_OFS_SRC) begin
				sel_r <= ets_src_type'(hwdata_i[ETS_SEL_LSB +: ETS_SEL_W]);
				cho_r <= hwdata_i[ETS_CHO_LSB +: 4];
				con_r <= hwdata_i[ETS_CON_LSB +: 7];
			end else if (wr_pend_r && addr_r == ETS_OFS_CFG) begin
				base_r <= hwdata_i[ETS_BASE_LSB +: 4];
				omni_r <= hwdata_i[ETS_OMNI_BIT];
				men_r  <= hwdata_i[ETS_MEN_BIT];
			end
			if (cap_r && msg.valid && cap_ok) begin
				// a capture landing with a select write still completes
				sel_r <= cap_src;
				if (msg.kind == K_CC) begin
					con_r <= msg.d1;
				end
				if (!omni_r && msg.kind != K_START && msg.kind != K_STOP) begin
					cho_r <= cap_cho;
				end
				cap_r <= 1'b0;
			end else if (cap_wr) begin
				cap_r <= ~cap_r;
			end
		end
	end

	// ---- pedal decode ----
	generate
		for (genvar s = 0; s < 2; s++) begin : g_ped
			assign three[s] = tr_ref_i[s] |
			                  (sel_r == (s == 0 ? SRC_TR1 : SRC_TR2));
			always_comb begin
				if (three[s]) begin
					ped[3*s]     = tip_i[s] & ~ring_i[s];
					ped[3*s + 1] = ring_i[s] & ~tip_i[s];
					ped[3*s + 2] = tip_i[s] & ring_i[s];
				end else begin
					ped[3*s]     = tip_i[s];
					ped[3*s + 1] = ring_i[s];
					ped[3*s + 2] = 1'b0;
				end
			end
		end
	endgenerate

	// ---- midi event matching ----
	assign cc_hit = msg.valid & (msg.kind == K_CC) & ch_ok;

	always_comb begin
		cc_sel = 1'b1;
		cc_num = CC_DAMP;
		case (sel_r)
			SRC_DAMP:  cc_num = CC_DAMP;
			SRC_PORTA: cc_num = CC_PORTA;
			SRC_SOST:  cc_num = CC_SOST;
			SRC_SOFT:  cc_num = CC_SOFT;
			SRC_HOLD2: cc_num = CC_HOLD2;
			SRC_GEN5, SRC_GEN6, SRC_GEN7, SRC_GEN8:
				cc_num = CC_GEN5 + {5'b00000, 2'(sel_r - SRC_GEN5)};
			default:   cc_sel = 1'b0;
		endcase
	end

	always_comb begin
		ev_hit = 1'b0;
		if (cc_sel) begin
			ev_hit = cc_hit & (msg.d1 == cc_num) & (msg.d2 == CC_ON);
		end else if (sel_r == SRC_NOTE) begin
			ev_hit = msg.valid & ch_ok &
			         ((msg.kind == K_NON) || (msg.kind == K_NOFF));
		end else if (sel_r == SRC_PROG) begin
			ev_hit = msg.valid & ch_ok & (msg.kind == K_PROG);
		end else if (sel_r == SRC_START) begin
			ev_hit = msg.valid & (msg.kind == K_START);
		end else if (sel_r == SRC_STOP) begin
			ev_hit = msg.valid & (msg.kind == K_STOP);
		end
	end

	// ---- double controller halves ----
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dbl_hi_r <= 7'h00;
			dbl_lo_r <= 7'h00;
		end else if (cc_hit && con_r <= DBL_MAX_CON) begin
			if (msg.d1 == con_r) begin
				dbl_hi_r <= msg.d2;
			end else if (msg.d1 == con_r + DBL_FINE_OFS) begin
				dbl_lo_r <= msg.d2;
			end
		end
	end

	// ---- level sources ----
	always_comb begin
		lvl_nxt = 1'b0;
		case (sel_r)
			SRC_TIP1:  lvl_nxt = ped[0];
			SRC_RING1: lvl_nxt = ped[1];
			SRC_TR1:   lvl_nxt = ped[2];
			SRC_TIP2:  lvl_nxt = ped[3];
			SRC_RING2: lvl_nxt = ped[4];
			SRC_TR2:   lvl_nxt = ped[5];
			SRC_MOD1, SRC_MOD2, SRC_MOD3, SRC_MOD4:
				lvl_nxt = mod_val_i[2'(sel_r - SRC_MOD1)] >= MOD_HALF;
			SRC_SINGLE: begin
				lvl_nxt = lvl_r;
				if (cc_hit && msg.d1 == con_r) begin
					lvl_nxt = msg.d2 >= HALF7;
				end
			end
			SRC_DOUBLE: begin
				lvl_nxt = lvl_r;
				// the level follows whichever half just arrived
				if (cc_hit && con_r <= DBL_MAX_CON) begin
					if (msg.d1 == con_r) begin
						lvl_nxt = {msg.d2, dbl_lo_r} >= HALF14;
					end else if (msg.d1 == con_r + DBL_FINE_OFS) begin
						lvl_nxt = {dbl_hi_r, msg.d2} >= HALF14;
					end
				end
			end
			default: lvl_nxt = 1'b0;
		endcase
	end

	// ---- trigger and activity outputs ----
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lvl_r  <= 1'b0;
			trig_r <= 1'b0;
		end else begin
			lvl_r  <= lvl_nxt;
			// a held level gives one pulse on its rising edge only
			trig_r <= (sel_r != SRC_OFF) & (ev_hit | (lvl_nxt & ~lvl_r));
		end
	end

	// single-cycle strobe; a visible lamp needs a stretcher outside
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= msg.valid & ~card_i;
		end
	end

endmodule : ets_trigger_sel

//--- design/ets_pkg.sv
// package for the external trigger selector: register map, field
// layout, source codes, midi constants and the message carrier.
// assumes a 32-bit ahb-lite register bus and 7-bit midi data bytes.
package ets_pkg;

	// register byte offsets
	localparam logic [7:0] ETS_OFS_SRC  = 8'h00;
	localparam logic [7:0] ETS_OFS_CFG  = 8'h04;
	localparam logic [7:0] ETS_OFS_CAP  = 8'h08;
	localparam logic [7:0] ETS_OFS_STAT = 8'h0C;

	// source register fields
	localparam int ETS_SEL_LSB = 0;
	localparam int ETS_SEL_W   = 5;
	localparam int ETS_CHO_LSB = 8;
	localparam int ETS_CON_LSB = 16;
	// config register fields
	localparam int ETS_BASE_LSB = 0;
	localparam int ETS_OMNI_BIT = 4;
	localparam int ETS_MEN_BIT  = 5;
	// capture register: write one toggles capture mode
	localparam int ETS_CAP_BIT = 0;
	// status register fields
	localparam int ETS_ST_CAP_BIT = 0;
	localparam int ETS_ST_LVL_BIT = 1;
	localparam int ETS_ST_PED_LSB = 2;
	localparam int ETS_ST_SEL_LSB = 8;

	// reset values
	localparam logic [3:0] ETS_BASE_RST = 4'h0;
	localparam logic       ETS_OMNI_RST = 1'b1;
	localparam logic       ETS_MEN_RST  = 1'b1;

	// trigger sources
	typedef enum logic [4:0] {
		SRC_OFF    = 5'h00, SRC_TIP1  = 5'h01, SRC_RING1 = 5'h02,
		SRC_TR1    = 5'h03, SRC_TIP2  = 5'h04, SRC_RING2 = 5'h05,
		SRC_TR2    = 5'h06, SRC_DAMP  = 5'h07, SRC_PORTA = 5'h08,
		SRC_SOST   = 5'h09, SRC_SOFT  = 5'h0A, SRC_HOLD2 = 5'h0B,
		SRC_GEN5   = 5'h0C, SRC_GEN6  = 5'h0D, SRC_GEN7  = 5'h0E,
		SRC_GEN8   = 5'h0F, SRC_NOTE  = 5'h10, SRC_PROG  = 5'h11,
		SRC_MOD1   = 5'h12, SRC_MOD2  = 5'h13, SRC_MOD3  = 5'h14,
		SRC_MOD4   = 5'h15, SRC_SINGLE = 5'h16, SRC_DOUBLE = 5'h17,
		SRC_START  = 5'h18, SRC_STOP  = 5'h19
	} ets_src_type;

	// controller numbers
	localparam logic [6:0] CC_DAMP  = 7'h40;
	localparam logic [6:0] CC_PORTA = 7'h41;
	localparam logic [6:0] CC_SOST  = 7'h42;
	localparam logic [6:0] CC_SOFT  = 7'h43;
	localparam logic [6:0] CC_HOLD2 = 7'h45;
	localparam logic [6:0] CC_GEN5  = 7'h50;
	localparam logic [6:0] CC_ON    = 7'h01;
	localparam logic [6:0] DBL_MAX_CON  = 7'h1F;
	localparam logic [6:0] DBL_FINE_OFS = 7'h20;
	localparam logic [6:0]  HALF7  = 7'h40;
	localparam logic [13:0] HALF14 = 14'h2000;
	localparam logic [7:0]  MOD_HALF = 8'h80;

	// message kinds: channel kinds are the status high nibble
	localparam logic [3:0] K_RT    = 4'h0;
	localparam logic [3:0] K_START = 4'h1;
	localparam logic [3:0] K_STOP  = 4'h2;
	localparam logic [3:0] K_NOFF  = 4'h8;
	localparam logic [3:0] K_NON   = 4'h9;
	localparam logic [3:0] K_CC    = 4'hB;
	localparam logic [3:0] K_PROG  = 4'hC;
	localparam logic [3:0] K_CHPR  = 4'hD;
	localparam logic [3:0] K_SYS   = 4'hF;
	localparam logic [7:0] B_SYS_MIN = 8'hF0;
	localparam logic [7:0] B_RT_MIN  = 8'hF8;
	localparam logic [7:0] B_START   = 8'hFA;
	localparam logic [7:0] B_STOP    = 8'hFC;
	localparam logic [4:0] CH_MAX    = 5'h0F;
	localparam logic [4:0] CH_COUNT  = 5'h10;

	typedef enum logic [2:0] {
		PS_WAIT = 3'b001,
		PS_D1   = 3'b010,
		PS_D2   = 3'b100
	} ets_pst_type;

	typedef struct packed {
		logic       valid;
		logic [3:0] kind;
		logic [3:0] chan;
		logic [6:0] d1;
		logic [6:0] d2;
	} ets_msg_type;

endpackage : ets_pkg

//--- design/ets_midi_parser.sv
// midi byte parser: running status, data byte assembly, one-cycle
// message strobe. assumes bytes arrive as a synchronous valid strobe.
`timescale 1ns/1ps
module ets_midi_parser (
	input  wire logic                 clk_i,       // system clock
	input  wire logic                 sys_rst_i,   // sync reset
	input  wire logic [7:0]           byte_i,      // received byte
	input  wire logic                 byte_vld_i,  // byte strobe
	input  wire logic                 midi_en_i,   // reception on
	output ets_pkg::ets_msg_type      msg_o        // message strobe
);
	import ets_pkg::*;

	ets_pst_type st_r;
	logic [7:0]  rs_r;
	logic [6:0]  d1_r;
	ets_msg_type msg_r;
	logic        one_data;

	// program change and channel pressure carry a single data byte
	assign one_data = (rs_r[7:4] == K_PROG) || (rs_r[7:4] == K_CHPR);
	assign msg_o    = msg_r;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r  <= PS_WAIT;
			rs_r  <= 8'h00;
			d1_r  <= 7'h00;
			msg_r <= '0;
		end else begin
			msg_r.valid <= 1'b0;
			if (!midi_en_i) begin
				// forget running status: data waits for fresh status
				st_r <= PS_WAIT;
				rs_r <= 8'h00;
			end else if (byte_vld_i) begin
				if (byte_i >= B_RT_MIN) begin
					// realtime bytes may interleave without breaking status
					msg_r.valid <= 1'b1;
					msg_r.kind  <= (byte_i == B_START) ? K_START :
					               (byte_i == B_STOP) ? K_STOP : K_RT;
				end else if (byte_i >= B_SYS_MIN) begin
					st_r        <= PS_WAIT;
					rs_r        <= 8'h00;
					msg_r.valid <= 1'b1;
					msg_r.kind  <= K_SYS;
				end else if (byte_i[7]) begin
					rs_r <= byte_i;
					st_r <= PS_D1;
				end else begin
					case (st_r)
						PS_D1: begin
							if (one_data) begin
								msg_r.valid <= 1'b1;
								msg_r.kind  <= rs_r[7:4];
								msg_r.chan  <= rs_r[3:0];
								msg_r.d1    <= byte_i[6:0];
								msg_r.d2    <= 7'h00;
							end else begin
								d1_r <= byte_i[6:0];
								st_r <= PS_D2;
							end
						end
						PS_D2: begin
							// data applies to last accepted status
							msg_r.valid <= 1'b1;
							msg_r.kind  <= rs_r[7:4];
							msg_r.chan  <= rs_r[3:0];
							msg_r.d1    <= d1_r;
							msg_r.d2    <= byte_i[6:0];
							st_r        <= PS_D1;
						end
						default: st_r <= PS_WAIT;
					endcase
				end
			end
		end
	end

endmodule : ets_midi_parser

//--- test/ets_trigger_sel_checker.sv
// checker for the trigger selector top: bus timing, pulse shapes, activity.
// assumes it is bound to ets_trigger_sel and sees only its ports.
`timescale 1ns/1ps
module ets_trigger_sel_checker (
	input wire logic            clk_i,       // clock
	input wire logic            sys_rst_i,   // sync reset
	input wire logic            hsel_i,      // ahb select
	input wire logic [1:0]      htrans_i,    // transfer type
	input wire logic            hwrite_i,    // write
	input wire logic            hready_i,    // bus ready
	input wire logic            hreadyout_o, // slave ready
	input wire logic [7:0]      midi_byte_i, // midi byte
	input wire logic            midi_vld_i,  // byte strobe
	input wire logic [1:0]      tip_i,       // tip contacts
	input wire logic [1:0]      ring_i,      // ring contacts
	input wire logic [1:0]      tr_ref_i,    // three-switch request
	input wire logic [3:0][7:0] mod_val_i,   // mod values
	input wire logic            card_i,      // card present
	input wire logic            trig_o,      // trigger pulse
	input wire logic            busy_o       // activity pulse
);
	logic       take;
	logic [3:0] quiet_r;
	assign take = hsel_i & htrans_i[1] & hready_i;
	// cycles since anything that may legally raise a trigger
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || take || midi_vld_i || tip_i != $past(tip_i) || ring_i != $past(ring_i)
			|| tr_ref_i != $past(tr_ref_i) || mod_val_i != $past(mod_val_i))
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_trig_pulse; trig_o |=> !trig_o; endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");
	property p_trig_cause; quiet_r >= 4'h6 |-> !trig_o; endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without activity");
	property p_busy_pulse; busy_o |=> !busy_o; endproperty
	a_busy_pulse: assert property (p_busy_pulse) else $error("activity longer than one cycle");
	property p_busy_card; card_i && $past(card_i) && $past(card_i, 2) |-> !busy_o; endproperty
	a_busy_card: assert property (p_busy_card) else $error("activity with card present");
	property p_busy_rt; midi_vld_i && midi_byte_i == 8'hFA && !card_i |-> ##[2:3] busy_o; endproperty
	a_busy_rt: assert property (p_busy_rt) else $error("no activity for a start byte");
	property p_rd_wait; take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait; take && hwrite_i |=> hreadyout_o; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_rst_out; disable iff (1'b0) sys_rst_i |=> !trig_o && !busy_o && hreadyout_o; endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not at reset level");
endmodule : ets_trigger_sel_checker

bind ets_trigger_sel ets_trigger_sel_checker u_chk (.clk_i, .sys_rst_i, .hsel_i, .htrans_i, .hwrite_i,
	.hready_i, .hreadyout_o, .midi_byte_i, .midi_vld_i, .tip_i, .ring_i, .tr_ref_i, .mod_val_i, .card_i,
	.trig_o, .busy_o);

//--- test/ets_far_model.sv
// far-side model: midi sender and the pedal sockets' contacts.
// assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module ets_far_model (
	input  wire logic  clk_i,       // system clock
	output logic [7:0] midi_byte_o, // midi byte
	output logic       midi_vld_o,  // byte strobe
	output logic [1:0] tip_o,       // tip shorted per socket
	output logic [1:0] ring_o       // ring shorted per socket
);
	initial begin
		midi_byte_o = 8'h00;
		midi_vld_o  = 1'b0;
		tip_o       = 2'b00;
		ring_o      = 2'b00;
	end
	// idle line shows the inverse so a stale byte never looks fresh
	task automatic send(input logic [7:0] b);
		@(posedge clk_i);
		midi_byte_o <= b;
		midi_vld_o  <= 1'b1;
		@(posedge clk_i);
		midi_vld_o  <= 1'b0;
		midi_byte_o <= ~b;
		repeat ($urandom_range(2)) @(posedge clk_i);
	endtask : send
	// status zero: running status, byte left out
	task automatic msg(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2, input int n);
		if (st != 8'h00)
			send(st);
		if (n > 0)
			send({1'b0, d1});
		if (n > 1)
			send({1'b0, d2});
	endtask : msg
	task automatic dbl(input logic [3:0] ch, input logic [4:0] con, input logic [13:0] v);
		msg({4'hB, ch}, {2'b00, con}, v[13:7], 2);
		msg(8'h00, {2'b01, con}, v[6:0], 2);
	endtask : dbl
	task automatic sw(input logic [1:0] t, input logic [1:0] r);
		@(posedge clk_i);
		tip_o  <= t;
		ring_o <= r;
	endtask : sw
endmodule : ets_far_model

//--- test/tb_top.sv
// bench for the trigger selector: registers, pedal, midi and mod sources,
// channels, capture, activity. assumes ets_far_model as the far side.
`timescale 1ns/1ps
module tb_top;
	import ets_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            hsel = 1'b0;
	logic [31:0]     haddr = 32'h0;
	logic [1:0]      htrans = 2'b00;
	logic            hwrite = 1'b0;
	logic [31:0]     hwdata = 32'h0;
	logic [1:0]      tr_ref = 2'b00;
	logic [3:0][7:0] mod = '0;
	logic            card = 1'b0;
	logic [31:0]     hrdata, rd;
	logic            hrdy, trig, busy, mvld, hresp;
	logic [7:0]      mbyte;
	logic [1:0]      tip, ring;
	logic [6:0]      con;
	int              fail_count = 0, cmp_count = 0, trig_n = 0, busy_n = 0, t0 = 0, b0 = 0, k;
	initial forever #5 clk = ~clk;
	ets_trigger_sel DUT (.clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
		.hreadyout_o(hrdy), .hresp_o(hresp), .midi_byte_i(mbyte), .midi_vld_i(mvld), .tip_i(tip),
		.ring_i(ring), .tr_ref_i(tr_ref), .mod_val_i(mod), .card_i(card), .trig_o(trig), .busy_o(busy));
	ets_far_model u_far (.clk_i(clk), .midi_byte_o(mbyte), .midi_vld_o(mvld), .tip_o(tip), .ring_o(ring));
	// pulses counted mid-cycle, clear of edge updates
	always @(negedge clk) begin
		trig_n += (trig === 1'b1);
		busy_n += (busy === 1'b1);
	end
	function automatic logic [3:0] chan(input logic [3:0] base, input logic [3:0] ofs);
		return base + ofs;
	endfunction : chan
	function automatic logic [31:0] src_w(input logic [4:0] s, input logic [3:0] o, input logic [6:0] c);
		return {9'h0, c, 4'h0, o, 3'h0, s};
	endfunction : src_w
	function automatic logic [31:0] stat_exp(input logic t, input logic r, input logic lvl);
		return {22'h0, 2'b01, 3'h0, t & r, r & ~t, t & ~r, lvl, 1'b0};
	endfunction : stat_exp
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic pulses(input int n);
		repeat (10) @(posedge clk);
		chk_cnt(trig_n - t0, n);
		t0 = trig_n;
	endtask : pulses
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		logic r;
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		// no wait limit here: only the watchdog ends a stalled transfer
		for (int p = 0; p < 2; p++) begin
			do begin
				@(negedge clk);
				r  = hrdy;
				rd = hrdata;
				@(posedge clk);
			end while (r !== 1'b1);
			hsel   <= 1'b0;
			htrans <= 2'b00;
			hwdata <= wd;
		end
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_reg(rd, exp);
		chk_reg({31'h0, hresp}, 32'h0);
	endtask : rdchk
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	initial begin
		#300000;
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'hBC9B297F));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdchk(ETS_OFS_CFG, 32'h00000030);
		rdchk(ETS_OFS_SRC, 32'h0);
		bus(1'b1, 8'h10, 32'hFFFFFFFF);
		rdchk(8'h10, 32'h0);
		u_far.sw(2'b11, 2'b11);
		mod <= {4{8'hFF}};
		u_far.msg(8'hB0, CC_DAMP, CC_ON, 2);
		pulses(0);
		u_far.sw(2'b00, 2'b00);
		mod <= '0;
		$display("test off done");
		bus(1'b1, ETS_OFS_SRC, SRC_RING1);
		u_far.sw(2'b01, 2'b00);
		u_far.sw(2'b01, 2'b01);
		pulses(1);
		u_far.sw(2'b00, 2'b00);
		tr_ref <= 2'b01;
		bus(1'b1, ETS_OFS_SRC, SRC_TIP1);
		u_far.sw(2'b01, 2'b01);
		u_far.sw(2'b01, 2'b00);
		pulses(1);
		u_far.sw(2'b00, 2'b00);
		tr_ref <= 2'b00;
		bus(1'b1, ETS_OFS_SRC, SRC_TR1);
		u_far.sw(2'b01, 2'b01);
		pulses(1);
		bus(1'b0, ETS_OFS_STAT, 32'h0);
		chk_reg(rd & 32'h3FE, stat_exp(1'b1, 1'b1, 1'b1));
		bus(1'b1, ETS_OFS_SRC, SRC_TR2);
		u_far.sw(2'b10, 2'b10);
		pulses(1);
		u_far.sw(2'b00, 2'b00);
		$display("test pedal done");
		for (int i = 0; i < 9; i++) begin
			con = (i < 4) ? 7'(CC_DAMP + i) : (i == 4) ? CC_HOLD2 : 7'(CC_GEN5 + i - 5);
			bus(1'b1, ETS_OFS_SRC, src_w(5'(SRC_DAMP + i), 4'h0, 7'h0));
			u_far.msg({K_CC, 4'($urandom_range(15))}, con, 7'h02, 2);
			u_far.msg(8'h00, con, CC_ON, 2);
			pulses(1);
		end
		bus(1'b1, ETS_OFS_SRC, SRC_NOTE);
		u_far.msg(8'h93, 7'h3C, 7'h00, 2);
		u_far.msg(8'h83, 7'h3C, 7'h40, 2);
		pulses(2);
		bus(1'b1, ETS_OFS_SRC, SRC_PROG);
		u_far.msg(8'hC5, 7'h05, 7'h00, 1);
		u_far.msg(8'h00, 7'h06, 7'h00, 1);
		pulses(2);
		k = $urandom_range(3);
		bus(1'b1, ETS_OFS_SRC, 5'(SRC_MOD1 + k));
		mod[k] <= 8'($urandom_range(127));
		@(posedge clk);
		mod[k] <= MOD_HALF;
		pulses(1);
		mod <= '0;
		$display("test events done");
		con = 7'($urandom_range(127));
		bus(1'b1, ETS_OFS_SRC, src_w(SRC_SINGLE, 4'h0, con));
		u_far.msg(8'hB0, con, 7'h3F, 2);
		u_far.msg(8'h00, con, HALF7, 2);
		u_far.msg(8'h00, con, 7'h7F, 2);
		u_far.msg(8'h00, con, 7'h3F, 2);
		u_far.msg(8'h00, con, 7'($urandom_range(127, 64)), 2);
		pulses(2);
		con = 7'($urandom_range(31));
		bus(1'b1, ETS_OFS_SRC, src_w(SRC_DOUBLE, 4'h0, con));
		for (int j = 0; j < 4; j++)
			u_far.dbl(4'h0, con[4:0], j[0] ? HALF14 : 14'h1FFF);
		pulses(2);
		$display("test levels done");
		bus(1'b1, ETS_OFS_CFG, 32'h29);
		bus(1'b1, ETS_OFS_SRC, src_w(SRC_DAMP, 4'hC, 7'h0));
		// matching channel last, so stale running status would fire below
		u_far.msg({K_CC, chan(4'h9, 4'hD)}, CC_DAMP, CC_ON, 2);
		u_far.msg({K_CC, chan(4'h9, 4'hC)}, CC_DAMP, CC_ON, 2);
		pulses(1);
		bus(1'b1, ETS_OFS_CFG, 32'h09);
		u_far.msg({K_CC, chan(4'h9, 4'hC)}, CC_DAMP, 7'h00, 2);
		bus(1'b1, ETS_OFS_CFG, 32'h29);
		u_far.msg(8'h00, CC_DAMP, CC_ON, 2);
		pulses(0);
		u_far.msg({K_CC, chan(4'h9, 4'hC)}, CC_DAMP, CC_ON, 2);
		pulses(1);
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, ETS_OFS_SRC, 5'(SRC_START + j));
			u_far.send(j ? B_STOP : B_START);
			pulses(1);
		end
		$display("test channels done");
		bus(1'b1, ETS_OFS_CAP, 32'h1);
		rdchk(ETS_OFS_CAP, 32'h1);
		u_far.msg(8'hB2, 7'h07, 7'h10, 2);
		rdchk(ETS_OFS_SRC, src_w(SRC_SINGLE, 4'(4'h2 - 4'h9), 7'h07));
		bus(1'b1, ETS_OFS_CAP, 32'h1);
		bus(1'b1, ETS_OFS_CAP, 32'h1);
		u_far.msg(8'hC0, 7'h01, 7'h00, 1);
		rdchk(ETS_OFS_SRC, src_w(SRC_SINGLE, 4'(4'h2 - 4'h9), 7'h07));
		rdchk(ETS_OFS_CAP, 32'h0);
		bus(1'b1, ETS_OFS_CFG, 32'h39);
		bus(1'b1, ETS_OFS_CAP, 32'h1);
		u_far.msg(8'h9E, 7'h3C, 7'h40, 2);
		rdchk(ETS_OFS_SRC, src_w(SRC_NOTE, 4'(4'h2 - 4'h9), 7'h07));
		$display("test capture done");
		b0 = busy_n;
		u_far.send(B_START);
		u_far.msg(8'h91, 7'h01, 7'h01, 2);
		repeat (10) @(posedge clk);
		chk_cnt(busy_n - b0, 2);
		card <= 1'b1;
		b0 = busy_n;
		u_far.send(B_START);
		repeat (10) @(posedge clk);
		chk_cnt(busy_n - b0, 0);
		$display("test activity done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(ETS_OFS_SRC, 32'h0);
		rdchk(ETS_OFS_CFG, 32'h00000030);
		$display("test reset done");
		close_out();
	end
endmodule : tb_top
